// ==== logic/lcr_pkg.sv ====
// constants, field layouts and the state record of the lcd command and reset block
// assumes one 40 mhz clock and a host that drives the bus pins asynchronously
// Notes on behaviour
// - pin reset or reset command initialises control
// - reset clears serial shifter, enters power saver
// - reset: display off, all on, normal polarity
// - reset zeroes page, column, line, directions, rmw
// - reset clears power, ratio; contrast 10000, 1/7
// - display ram contents survive every reset
// - drive voltage shorted on resets; booster on pin only
// - 8080 style: low read or write strobe
// - 6800 style: direction level, high enable pulse
// - select line classifies command versus display data
// - serial bytes arrive most significant bit first
// - 1010111x switches display off or on
// - display off with all on means power saver
// - 1010011x picks normal or reverse polarity
// - 1010010x forces all pixels, overrides polarity
// - 1011xxxx loads page address 0 to 8
// - past column 83h page steps, page 8 wraps
// - indicator page stores only data bit 0
// - bias command selects 1/7 or 1/9 bias
// - each write, and each read outside rmw, steps column, 83h wraps
package lcr_pkg;
    localparam int unsigned COLS      = 132;          // columns per page
    localparam int unsigned PAGES     = 9;            // eight graphic pages and the indicator page
    localparam int unsigned RAM_DEPTH = COLS * PAGES; // display ram bytes
    localparam int unsigned RAM_AW    = 11;           // display ram address width
    localparam logic [7:0]  COL_LAST  = 8'h83;        // last column before wrap
    localparam logic [3:0]  PAGE_LAST = 4'h8;         // indicator page, last page
    localparam logic [7:0]  COL_RST   = 8'h00;
    localparam logic [3:0]  PAGE_RST  = 4'h0;
    localparam logic [5:0]  LINE_RST  = 6'h00;
    localparam logic [2:0]  PWR_RST   = 3'h0;
    localparam logic [2:0]  RATIO_RST = 3'h0;
    localparam logic [4:0]  VOL_RST   = 5'h10;
    localparam logic        BIAS9_RST = 1'b0;         // zero selects 1/7 bias
    localparam logic [7:0]  RESET_CMD = 8'he2;        // software reset
    localparam logic [7:0]  RMW_CMD   = 8'he0;        // read modify write entry
    localparam logic [7:0]  END_CMD   = 8'hee;        // read modify write exit
    // bit positions in the synchronised pin vector
    localparam int unsigned SYNC_W = 16;
    localparam int unsigned SB_RES = 15;
    localparam int unsigned SB_RD  = 14;
    localparam int unsigned SB_WR  = 13;
    localparam int unsigned SB_A0  = 12;
    localparam int unsigned SB_SCL = 11;
    localparam int unsigned SB_SI  = 10;
    localparam int unsigned SB_DLO = 2;
    localparam int unsigned SB_M68 = 1;
    localparam int unsigned SB_SER = 0;

    // whole state of the top module
    typedef struct packed {
        logic [15:0] s1;         // first synchroniser stage
        logic [15:0] s2;         // second stage
        logic [15:0] s3;         // third stage
        logic [15:0] flt;        // levels accepted once stages two and three agree
        logic [7:0]  sh;         // serial shift register
        logic [2:0]  cnt;        // serial bit counter
        logic        disp_on;
        logic        reverse;
        logic        all_on;
        logic        psave;
        logic        drv_gnd;
        logic        osc_run;
        logic        sup_run;
        logic [3:0]  page;
        logic [7:0]  col;
        logic [7:0]  rmw_col;    // column saved on read modify write entry
        logic [5:0]  line;
        logic        seg_rev;
        logic        com_rev;
        logic        rmw;
        logic [2:0]  pwr;
        logic [2:0]  ratio;
        logic [4:0]  vol;
        logic        bias9;
        logic        v0_short;
        logic        vout_short;
        logic [7:0]  rd_buf;     // read pipeline latch
        logic [7:0]  dout;
        logic        doe;
    } lcr_state_t;
endpackage

// ==== logic/lcr_ram.sv ====
// display ram: one write port, one registered read port
// assumes addresses below DEPTH; nothing here is touched by any reset
`timescale 1ns/100ps
module lcr_ram #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 1188,
    parameter int unsigned AW    = 11
) (
    input  wire logic             ref_clk_in,
    input  wire logic             we_in,
    input  wire logic [AW-1:0]    addr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic      [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem [DEPTH];   // array with no reset so contents persist

    // write and read share one address; read data is registered
    always_ff @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

// ==== logic/lcr_core.sv ====
// lcd command decoder, reset control and display ram address path
// assumes bus and serial pins are asynchronous to ref_clk_in and held steady around strobes
`timescale 1ns/100ps
module lcr_core #(
    parameter logic HAS_INT_SUPPLY = 1'b1  // variant with on-chip supply and discharge switches
) (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       hw_reset_n_pin_in,
    input  wire logic       rd_strobe_n_in,      // read strobe, or enable in 6800 style
    input  wire logic       wr_strobe_n_in,      // write strobe, or direction in 6800 style
    input  wire logic       cmd_data_select_in,
    input  wire logic [7:0] data_in,
    input  wire logic       bus_6800_in,
    input  wire logic       serial_sel_in,
    input  wire logic       serial_clk_in,
    input  wire logic       serial_data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_out,
    output logic            display_on_out,
    output logic            reverse_out,
    output logic            all_on_out,
    output logic            power_save_out,
    output logic            drivers_gnd_out,
    output logic            osc_run_out,
    output logic            supply_run_out,
    output logic      [3:0] page_out,
    output logic      [7:0] column_out,
    output logic      [5:0] start_line_out,
    output logic            seg_rev_out,
    output logic            com_rev_out,
    output logic            rmw_out,
    output logic      [2:0] power_ctrl_out,
    output logic      [2:0] ratio_out,
    output logic      [4:0] contrast_out,
    output logic            bias_ninth_out,
    output logic            v0_short_out,
    output logic            vout_short_out
);
    lcr_pkg::lcr_state_t q;          // registered state
    lcr_pkg::lcr_state_t n;          // next state
    logic [15:0] pins;               // raw pin vector
    logic [15:0] flt_new;            // accepted levels this cycle
    logic        rd_old;             // read active, previous accepted level
    logic        rd_now;
    logic        wr_old;
    logic        wr_now;
    logic        par_wr_ev;          // parallel write started
    logic        rd_ev;              // parallel read started
    logic        ser_ev;             // eighth serial bit shifted
    logic        scl_rise;
    logic [7:0]  byte_val;           // byte of the current write
    logic        byte_a0;
    logic        cmd_ev;             // command byte taken
    logic        data_ev;            // display data write taken
    logic        rdd_ev;             // display data read taken
    logic        pin_low;            // accepted hardware reset level
    logic [3:0]  cmd_lo;
    logic        ram_we;
    logic [10:0] ram_addr;
    logic [7:0]  ram_wdata;
    logic [7:0]  ram_rdata;

    // step column, carrying into page and wrapping after the indicator page
    function automatic logic [11:0] lcr_advance(input logic [3:0] pg, input logic [7:0] cl);
        logic [11:0] r;
        r = {pg, cl + 8'h01};
        if (cl == lcr_pkg::COL_LAST) begin
            r[7:0] = lcr_pkg::COL_RST;
            r[11:8] = (pg == lcr_pkg::PAGE_LAST) ? lcr_pkg::PAGE_RST : pg + 4'h1;
        end
        return r;
    endfunction

    // control state after either reset source; ram and synchronisers untouched
    function automatic lcr_pkg::lcr_state_t lcr_init(input lcr_pkg::lcr_state_t s,
                                                     input logic pin);
        lcr_pkg::lcr_state_t r;
        r = s;
        r.sh = 8'h00;
        r.cnt = 3'h0;
        r.disp_on = 1'b0;
        r.all_on = 1'b1;
        r.reverse = 1'b0;
        r.psave = 1'b1;
        r.osc_run = 1'b0;
        r.sup_run = 1'b0;
        r.drv_gnd = 1'b1;
        r.page = lcr_pkg::PAGE_RST;
        r.col = lcr_pkg::COL_RST;
        r.line = lcr_pkg::LINE_RST;
        r.seg_rev = 1'b0;
        r.com_rev = 1'b0;
        r.rmw = 1'b0;
        r.pwr = lcr_pkg::PWR_RST;
        r.ratio = lcr_pkg::RATIO_RST;
        r.vol = lcr_pkg::VOL_RST;
        r.bias9 = lcr_pkg::BIAS9_RST;
        r.v0_short = HAS_INT_SUPPLY;
        r.vout_short = HAS_INT_SUPPLY & pin;
        return r;
    endfunction

    assign pins = {hw_reset_n_pin_in, rd_strobe_n_in, wr_strobe_n_in, cmd_data_select_in,
                   serial_clk_in, serial_data_in, data_in, bus_6800_in, serial_sel_in};
    // a level counts only once the second and third stages agree
    assign flt_new = (q.s3 & ~(q.s2 ^ q.s3)) | (q.flt & (q.s2 ^ q.s3));
    assign pin_low = ~flt_new[lcr_pkg::SB_RES];

    // strobe decode per bus style; 6800 uses enable high with direction level
    assign rd_old = q.flt[lcr_pkg::SB_M68] ? (q.flt[lcr_pkg::SB_RD] & q.flt[lcr_pkg::SB_WR])
                                            : ~q.flt[lcr_pkg::SB_RD];
    assign rd_now = flt_new[lcr_pkg::SB_M68] ? (flt_new[lcr_pkg::SB_RD] & flt_new[lcr_pkg::SB_WR])
                                              : ~flt_new[lcr_pkg::SB_RD];
    assign wr_old = q.flt[lcr_pkg::SB_M68] ? (q.flt[lcr_pkg::SB_RD] & ~q.flt[lcr_pkg::SB_WR])
                                            : ~q.flt[lcr_pkg::SB_WR];
    assign wr_now = flt_new[lcr_pkg::SB_M68] ? (flt_new[lcr_pkg::SB_RD] & ~flt_new[lcr_pkg::SB_WR])
                                              : ~flt_new[lcr_pkg::SB_WR];
    // the parallel port is dead while the serial port is selected
    assign par_wr_ev = ~flt_new[lcr_pkg::SB_SER] & wr_now & ~wr_old;
    assign rd_ev = ~flt_new[lcr_pkg::SB_SER] & rd_now & ~rd_old;
    assign scl_rise = flt_new[lcr_pkg::SB_SER] & flt_new[lcr_pkg::SB_SCL]
                      & ~q.flt[lcr_pkg::SB_SCL];
    assign ser_ev = scl_rise & (q.cnt == 3'h7);
    // serial bytes fill from bit 7 downward
    assign byte_val = ser_ev ? {q.sh[6:0], flt_new[lcr_pkg::SB_SI]}
                             : flt_new[lcr_pkg::SB_DLO +: 8];
    assign byte_a0 = flt_new[lcr_pkg::SB_A0];
    assign cmd_ev = (par_wr_ev | ser_ev) & ~byte_a0 & ~pin_low;
    assign data_ev = (par_wr_ev | ser_ev) & byte_a0 & ~pin_low;
    assign rdd_ev = rd_ev & byte_a0 & ~pin_low;
    assign cmd_lo = byte_val[3:0];

    // ram port: indicator page keeps only bit 0
    assign ram_we = data_ev;
    assign ram_addr = 11'(({7'h00, q.page} * 11'(lcr_pkg::COLS)) + {3'h0, q.col});
    assign ram_wdata = (q.page == lcr_pkg::PAGE_LAST) ? {7'h00, byte_val[0]} : byte_val;

    lcr_ram #(
        .WIDTH (8),
        .DEPTH (lcr_pkg::RAM_DEPTH),
        .AW    (lcr_pkg::RAM_AW)
    ) u_ram (
        .ref_clk_in (ref_clk_in),
        .we_in      (ram_we),
        .addr_in    (ram_addr),
        .wdata_in   (ram_wdata),
        .rdata_out  (ram_rdata)
    );

    // next state: synchronisers, serial shifter, decoder, access path, derived levels
    always_comb begin
        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.flt = flt_new;
        if (scl_rise) begin
            n.sh = {q.sh[6:0], flt_new[lcr_pkg::SB_SI]};
            n.cnt = q.cnt + 3'h1;
        end
        if (cmd_ev) begin
            casez (byte_val)
                8'b0000_????: if (!q.rmw) n.col[3:0] = cmd_lo;   // column low nibble
                8'b0001_????: if (!q.rmw) n.col[7:4] = cmd_lo;   // column high nibble
                8'b0010_0???: n.ratio = byte_val[2:0];
                8'b0010_1???: n.pwr = byte_val[2:0];
                8'b01??_????: n.line = byte_val[5:0];
                8'b100?_????: n.vol = byte_val[4:0];
                8'b1010_000?: n.seg_rev = byte_val[0];
                8'b1010_001?: n.bias9 = byte_val[0];
                8'b1010_010?: n.all_on = byte_val[0];
                8'b1010_011?: n.reverse = byte_val[0];
                8'b1010_111?: n.disp_on = byte_val[0];
                8'b1011_????: begin
                    // codes above the indicator page are not pages at all
                    if (cmd_lo <= lcr_pkg::PAGE_LAST) begin
                        n.page = cmd_lo;
                    end
                end
                8'b1100_????: n.com_rev = byte_val[3];
                lcr_pkg::RMW_CMD: begin
                    n.rmw = 1'b1;
                    n.rmw_col = q.col;
                end
                lcr_pkg::END_CMD: begin
                    // only the column returns; the page stays where it is
                    if (q.rmw) begin
                        n.col = q.rmw_col;
                    end
                    n.rmw = 1'b0;
                end
                lcr_pkg::RESET_CMD: n = lcr_init(n, 1'b0);
                default: ;
            endcase
        end
        if (data_ev) begin
            {n.page, n.col} = lcr_advance(q.page, q.col);
        end
        // read hands out the previous fetch, so the first read after addressing is a dummy
        if (rdd_ev) begin
            n.dout = q.rd_buf;
            n.rd_buf = ram_rdata;
            if (!q.rmw) begin
                {n.page, n.col} = lcr_advance(q.page, q.col);
            end
        end
        n.doe = rd_now & byte_a0 & ~flt_new[lcr_pkg::SB_SER] & ~pin_low;
        if (pin_low) begin
            n = lcr_init(n, 1'b1);
            n.doe = 1'b0;
        end else begin
            n.vout_short = 1'b0;
        end
        // drive voltage stays shorted until the supply is switched on again
        if (!pin_low && (n.pwr != lcr_pkg::PWR_RST) && !n.psave) begin
            n.v0_short = 1'b0;
        end
        n.psave = ~n.disp_on & n.all_on;
        n.osc_run = ~n.psave;
        n.sup_run = ~n.psave & (n.pwr != lcr_pkg::PWR_RST);
        n.drv_gnd = ~n.disp_on | n.psave;
    end

    // one register for the whole state
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            q <= lcr_init(lcr_pkg::lcr_state_t'('0), 1'b1);
        end else begin
            q <= n;
        end
    end

    assign data_out = q.dout;
    assign data_oe_out = q.doe;
    assign display_on_out = q.disp_on;
    assign reverse_out = q.reverse;
    assign all_on_out = q.all_on;
    assign power_save_out = q.psave;
    assign drivers_gnd_out = q.drv_gnd;
    assign osc_run_out = q.osc_run;
    assign supply_run_out = q.sup_run;
    assign page_out = q.page;
    assign column_out = q.col;
    assign start_line_out = q.line;
    assign seg_rev_out = q.seg_rev;
    assign com_rev_out = q.com_rev;
    assign rmw_out = q.rmw;
    assign power_ctrl_out = q.pwr;
    assign ratio_out = q.ratio;
    assign contrast_out = q.vol;
    assign bias_ninth_out = q.bias9;
    assign v0_short_out = q.v0_short;
    assign vout_short_out = q.vout_short;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_cmd(logic [7:0] c);
        cmd_ev && (byte_val == c);
    endsequence
    sequence s_pin_reset;
        pin_low ##1 !display_on_out && all_on_out;
    endsequence

    property p_pin_init;
        s_pin_reset |-> (contrast_out == 5'h10) && (page_out == 4'h0) && !reverse_out;
    endproperty
    a_pin_init: assert property (p_pin_init) else $error("pin reset state wrong");
    property p_ser_clear;
        pin_low |=> (q.cnt == 3'h0) && power_save_out && !osc_run_out;
    endproperty
    a_ser_clear: assert property (p_ser_clear) else $error("serial not cleared");
    property p_disp_on;
        s_cmd(8'haf) ##1 !pin_low |-> display_on_out;
    endproperty
    a_disp_on: assert property (p_disp_on) else $error("display on ignored");
    // saver follows from either order of the two commands, not from the register itself
    property p_psave;
        ((s_cmd(8'hae) ##0 all_on_out) or (s_cmd(8'ha5) ##0 !display_on_out)) ##1 !pin_low
            |-> power_save_out && !osc_run_out;
    endproperty
    a_psave: assert property (p_psave) else $error("power saver mismatch");
    property p_reverse;
        s_cmd(8'ha7) ##1 !pin_low |-> reverse_out ##1 $stable(reverse_out) || cmd_ev;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse not set");
    property p_page;
        cmd_ev && (byte_val[7:4] == 4'hb) && (cmd_lo <= 4'h8) ##1 !pin_low
            |-> page_out == $past(cmd_lo);
    endproperty
    a_page: assert property (p_page) else $error("page not loaded");
    property p_wrap;
        data_ev && (q.col == 8'h83) && (q.page == 4'h8) ##1 !pin_low
            |-> (page_out == 4'h0) && (column_out == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap");
    property p_indicator;
        ram_we && (q.page == 4'h8) |-> ram_wdata[7:1] == 7'h00;
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator bits stored");
    property p_unknown;
        s_cmd(8'hf5) ##1 !pin_low |-> $stable(contrast_out) && $stable(page_out)
            && $stable(display_on_out) && $stable(ratio_out);
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown command acted");
    property p_vout;
        vout_short_out |-> HAS_INT_SUPPLY && !q.flt[15];
    endproperty
    a_vout: assert property (p_vout) else $error("booster short without pin reset");
endmodule

// ==== verification/lcr_host.sv ====
// host model: drives the parallel bus, the serial port and the reset pin
// assumes one 40 mhz clock shared with the block; every change lands 2 ns after an edge
`timescale 1ns/100ps
module lcr_host (
    input  wire logic       ref_clk_in,
    input  wire logic [7:0] data_in,       // read data from the block
    input  wire logic       data_oe_in,    // block drives the data bus
    output logic            res_n_out,     // hardware reset pin, active low
    output logic            rd_n_out,      // read strobe, or enable in 6800 style
    output logic            wr_n_out,      // write strobe, or direction in 6800 style
    output logic            sel_out,       // command or display data select
    output logic      [7:0] data_out,
    output logic            m68_out,
    output logic            ser_out,
    output logic            sclk_out,      // stands still low between bytes
    output logic            sdat_out
);
    logic [1:0] cur;                       // current bus style: 0 8080, 1 6800, 2 serial

    // power-on state: reset pin held low until the bench lets go
    initial begin
        res_n_out = 1'b0;
        {rd_n_out, wr_n_out, sel_out, m68_out, ser_out, sclk_out, sdat_out} = 7'h60;
        data_out = 8'h5a;
        cur = 2'h0;
    end

    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask

    // switch bus style while idle; enable and style move together so no strobe is seen
    task automatic mode(input logic [1:0] m);
        m68_out = (m == 2'h1);
        rd_n_out = (m != 2'h1);
        ser_out = (m == 2'h2);
        cur = m;
        tick(8);
    endtask

    // reset pin level; low discharges the panel when the supply goes off
    task automatic pin(input logic lvl);
        res_n_out = lvl;
        tick(8);
    endtask

    // one write of n bits (serial) or one byte (parallel)
    task automatic put(input logic [1:0] m, input logic sel, input logic [7:0] b, input int n);
        int i;
        if (m != cur) mode(m);
        sel_out = sel;
        if (m == 2'h2) begin
            for (i = 7; i > 7 - n; i--) begin
                sdat_out = b[i];
                tick(3);
                sclk_out = 1'b1;
                tick(4);
                sclk_out = 1'b0;
            end
            tick(4);
            sdat_out = ~sdat_out;  // released line shows no stale level
        end else begin
            data_out = b;
            if (m == 2'h1) wr_n_out = 1'b0;
            tick(2);
            if (m == 2'h1) rd_n_out = 1'b1;
            else wr_n_out = 1'b0;
            tick(6);
            if (m == 2'h1) rd_n_out = 1'b0;
            else wr_n_out = 1'b1;
            tick(6);
            wr_n_out = 1'b1;
            data_out = ~b;  // hold time over: bus shows the complement of the byte
        end
        // an edge passes so the next transfer never reassigns a line in this step
        tick(1);
    endtask

    // one display data read; a bus the block does not drive reads as z
    task automatic get(input logic [1:0] m, output logic [7:0] v);
        if (m != cur) mode(m);
        sel_out = 1'b1;
        tick(2);
        rd_n_out = (m == 2'h1);
        tick(8);
        v = data_oe_in ? data_in : 8'hzz;
        rd_n_out = (m != 2'h1);
        tick(6);
    endtask
endmodule

// ==== verification/lcr_command_reset_control_tb.sv ====
// self-checking bench for the lcd command and reset block
// assumes lcr_host as the only bus master; no random stimulus
`timescale 1ns/100ps
module lcr_command_reset_control_tb;
    typedef struct packed {
        logic [7:0] cmd;
        logic [1:0] mode;   // bus style of the row
        logic [5:0] flags;  // on, reverse, all on, saver, ground, ninth bias
        logic [3:0] pg;
    } lcr_row_t;

    logic       ref_clk, reset_n;
    logic       res_n, rd_n, wr_n, sel, m68, ser, sclk, sdat, oe;
    logic [7:0] hdata, dout, col;
    logic       on, rev, all, ps, gnd, osc, sup, segr, comr, rmw, bias9, v0s, vos;
    logic [3:0] page;
    logic [5:0] line;
    logic [2:0] pwr, ratio;
    logic [4:0] vol;
    int         err_count, checks;
    wire  [5:0] flags = {on, rev, all, ps, gnd, bias9};
    wire [39:0] snap = {on, rev, all, ps, gnd, osc, sup, segr, comr, rmw, bias9,
                        page, col, line, pwr, ratio, vol};
    // whole control state expected after any reset
    localparam logic [39:0] SNAP_RST = {10'h0e0, lcr_pkg::BIAS9_RST, lcr_pkg::PAGE_RST,
        lcr_pkg::COL_RST, lcr_pkg::LINE_RST, lcr_pkg::PWR_RST, lcr_pkg::RATIO_RST,
        lcr_pkg::VOL_RST};
    // ordinary commands, styles rotating up to the last row, each with the state it should leave
    lcr_row_t rows [14] = '{
        '{8'haf, 2'h0, 6'h28, 4'h0}, '{8'ha4, 2'h1, 6'h20, 4'h0},
        '{8'ha7, 2'h2, 6'h30, 4'h0}, '{8'ha6, 2'h0, 6'h20, 4'h0},
        '{8'ha5, 2'h1, 6'h28, 4'h0}, '{8'hae, 2'h2, 6'h0e, 4'h0},
        '{8'ha4, 2'h0, 6'h02, 4'h0}, '{8'ha3, 2'h1, 6'h03, 4'h0},
        '{8'hb8, 2'h2, 6'h03, 4'h8}, '{8'hb9, 2'h0, 6'h03, 4'h8},
        '{8'hf5, 2'h1, 6'h03, 4'h8}, '{8'ha2, 2'h2, 6'h02, 4'h8},
        '{8'hb3, 2'h0, 6'h02, 4'h3}, '{8'haf, 2'h0, 6'h20, 4'h3}};

    // host on the bus side, no input of the block tied off
    lcr_host h (.ref_clk_in(ref_clk), .data_in(dout), .data_oe_in(oe), .res_n_out(res_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel), .data_out(hdata), .m68_out(m68),
        .ser_out(ser), .sclk_out(sclk), .sdat_out(sdat));

    lcr_core uut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .hw_reset_n_pin_in(res_n),
        .rd_strobe_n_in(rd_n), .wr_strobe_n_in(wr_n), .cmd_data_select_in(sel),
        .data_in(hdata), .bus_6800_in(m68), .serial_sel_in(ser), .serial_clk_in(sclk),
        .serial_data_in(sdat), .data_out(dout), .data_oe_out(oe), .display_on_out(on),
        .reverse_out(rev), .all_on_out(all), .power_save_out(ps), .drivers_gnd_out(gnd),
        .osc_run_out(osc), .supply_run_out(sup), .page_out(page), .column_out(col),
        .start_line_out(line), .seg_rev_out(segr), .com_rev_out(comr), .rmw_out(rmw),
        .power_ctrl_out(pwr), .ratio_out(ratio), .contrast_out(vol),
        .bias_ninth_out(bias9), .v0_short_out(v0s), .vout_short_out(vos));

    // 40 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // compare with case equality so an unknown never matches
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // page, column high nibble, column low nibble
    task automatic cmds(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        h.put(2'h0, 1'b0, a, 8);
        h.put(2'h0, 1'b0, b, 8);
        h.put(2'h0, 1'b0, c, 8);
    endtask

    // dummy read after addressing, then the read that counts
    task automatic rd2(input logic [1:0] m, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        h.get(m, v);
        h.get(m, v);
        check(nm, {32'h0, v}, {32'h0, exp});
    endtask

    task automatic print_verdict();
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // main sequence: table first, then addressing and ram, supply, resets, read modify write
    initial begin
        err_count = 0;
        checks = 0;
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2 reset_n = 1'b1;
        h.tick(6);
        check("reset state", snap, SNAP_RST);
        h.pin(1'b1);
        for (int i = 0; i < 14; i++) begin
            h.put(rows[i].mode, 1'b0, rows[i].cmd, 8);
            check("flags", {34'h0, flags}, {34'h0, rows[i].flags});
            check("page", {36'h0, page}, {36'h0, rows[i].pg});
        end
        cmds(8'hb2, 8'h10, 8'h05);
        h.put(2'h1, 1'b1, 8'ha5, 8);
        check("column step", {32'h0, col}, 40'h06);
        cmds(8'hb2, 8'h10, 8'h05);
        rd2(2'h0, 8'ha5, "readback");
        cmds(8'hb7, 8'h18, 8'h03);
        h.put(2'h0, 1'b1, 8'h3c, 8);
        check("page step", {28'h0, page, col}, 40'h800);
        h.put(2'h0, 1'b1, 8'hff, 8);
        cmds(8'hb8, 8'h18, 8'h03);
        h.put(2'h2, 1'b1, 8'hff, 8);
        check("page wrap", {28'h0, page, col}, 40'h000);
        cmds(8'hb8, 8'h10, 8'h00);
        rd2(2'h1, 8'h01, "indicator");
        // supply enabled before ratio and contrast are trusted
        h.put(2'h1, 1'b0, 8'h2f, 8);
        h.put(2'h1, 1'b0, 8'h27, 8);
        h.put(2'h1, 1'b0, 8'h9f, 8);
        check("supply", {27'h0, pwr, ratio, vol, sup, v0s}, {27'h0, 13'h1ffe});
        // pin reset in mid serial byte must drop the partial bits
        h.put(2'h2, 1'b0, 8'hff, 3);
        h.pin(1'b0);
        check("pin shorts", {38'h0, v0s, vos}, 40'h3);
        h.pin(1'b1);
        check("pin reset", snap, SNAP_RST);
        h.put(2'h2, 1'b0, 8'haf, 8);
        check("serial restart", {34'h0, flags}, 40'h28);
        h.put(2'h0, 1'b0, 8'h2f, 8);
        h.put(2'h0, 1'b0, lcr_pkg::RESET_CMD, 8);
        check("command reset", snap, SNAP_RST);
        check("command shorts", {38'h0, v0s, vos}, 40'h2);
        // read modify write: reads hold the column, writes step it, exit restores it
        cmds(8'hb2, 8'h10, 8'h05);
        h.put(2'h0, 1'b0, lcr_pkg::RMW_CMD, 8);
        rd2(2'h0, 8'ha5, "ram kept");
        h.put(2'h0, 1'b1, 8'h5a, 8);
        check("rmw write", {31'h0, rmw, col}, 40'h106);
        h.put(2'h0, 1'b0, lcr_pkg::END_CMD, 8);
        check("rmw end", {31'h0, rmw, col}, 40'h005);
        print_verdict();
    end

    // the sequence needs about 1300 cycles; cut a hang well past that
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
endmodule
